// File: src/pwmirq_params.svh
`ifndef PWMIRQ_PARAMS_SVH
`define PWMIRQ_PARAMS_SVH

// register byte offsets
`define PWMIRQ_OFS_MASK     12'h300
`define PWMIRQ_OFS_MASK_SET 12'h304
`define PWMIRQ_OFS_MASK_CLR 12'h308
`define PWMIRQ_OFS_STATUS   12'h320
`define PWMIRQ_OFS_PENDING  12'h324
`define PWMIRQ_OFS_MODULE   12'h500
`define PWMIRQ_OFS_WMODE    12'h504

// event bit positions
`define PWMIRQ_BIT_HALT     1
`define PWMIRQ_BIT_PBEGIN0  2
`define PWMIRQ_BIT_PBEGIN1  3
`define PWMIRQ_BIT_PFIN0    4
`define PWMIRQ_BIT_PFIN1    5
`define PWMIRQ_BIT_WRAP     6
`define PWMIRQ_BIT_REPEAT   7
`define PWMIRQ_EVT_W        8
`define PWMIRQ_EVT_VALID    8'hFE

// field positions and reset values
`define PWMIRQ_BIT_ON       0
`define PWMIRQ_BIT_WMODE    0
`define PWMIRQ_RST_WORD     32'h0000_0000
`define PWMIRQ_RST_EVT      8'h00
`define PWMIRQ_RST_BIT      1'b0

`endif

// File: src/pwmirq_pkg.sv
package pwmirq_pkg;

  typedef logic [7:0]  pwmirq_evt_t;
  typedef logic [31:0] pwmirq_word_t;
  typedef logic [11:0] pwmirq_addr_t;

  // wave counter direction
  typedef enum logic [0:0] {
    PWMIRQ_WAVE_UP     = 1'b0,
    PWMIRQ_WAVE_UPDOWN = 1'b1
  } pwmirq_wave_e;

endpackage

// File: src/pwmirq_evt_if.sv
`timescale 1ns/1ps
interface pwmirq_evt_if;
  import pwmirq_pkg::*;

  pwmirq_evt_t set;
  pwmirq_evt_t clr;
  pwmirq_evt_t flags;

  modport owner (
    input  set,
    input  clr,
    output flags
  );

  modport user (
    output set,
    output clr,
    input  flags
  );
endinterface

// File: src/pwmirq_evt_flags.sv
`timescale 1ns/1ps
`include "pwmirq_params.svh"
module pwmirq_evt_flags
  import pwmirq_pkg::*;
(
  input  wire logic    pclk,
  input  wire logic    presetn,
  pwmirq_evt_if.owner  evt
);

  // ----------------------------------------
  // sticky event flags
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PWMIRQ_EVT_W; g++) begin : g_flag
      logic flag_q;
      logic flag_d;

      // a set in the same cycle as a clear wins, so no event is lost
      assign flag_d = evt.set[g] | (flag_q & ~evt.clr[g]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_q <= `PWMIRQ_RST_BIT;
        end else begin
          flag_q <= flag_d;
        end
      end

      assign evt.flags[g] = flag_q;
    end
  endgenerate

endmodule

// File: src/pwmirq_top.sv
// Summary of operation
// - writing one to set register halt bit enables its interrupt; reads show enable
// - set register pattern-begin bits enable matching sequence-start interrupts
// - set register pattern-finish bits enable matching sequence-end interrupts
// - set register cycle-wrap bit enables period-end interrupt
// - set register repeat-complete bit enables loops-done interrupt
// - writing one to clear register halt bit disables it; reads show enable
// - clear register pattern-begin bits disable matching sequence-start interrupts
// - clear register pattern-finish bits disable matching sequence-end interrupts
// - clear register cycle-wrap bit disables period-end interrupt
// - clear register repeat-complete bit disables loops-done interrupt
// - module enable bit 0 switches modulator on; resets to off
// - a register selects the wave counter operating mode
// - set, clear and plain mask registers share one set of enable bits
`timescale 1ns/1ps
`include "pwmirq_params.svh"
module pwmirq_top
  import pwmirq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        halt_done_event,
  input  wire logic [1:0]  pattern_begin_event,
  input  wire logic [1:0]  pattern_finish_event,
  input  wire logic        cycle_wrap_event,
  input  wire logic        repeat_complete_event,
  output logic             module_on,
  output logic             wave_mode,
  output logic             irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  pwmirq_evt_t  mask_q;
  pwmirq_evt_t  mask_d;
  logic         on_q;
  logic         on_d;
  pwmirq_wave_e wmode_q;
  pwmirq_wave_e wmode_d;
  pwmirq_word_t rdata_q;
  pwmirq_word_t rdata_d;
  logic         irq_q;

  pwmirq_evt_if evt ();

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire logic setup_ph = psel & ~penable;
  wire logic access_ph = psel & penable;
  wire logic wr_en = access_ph & pwrite;

  wire logic hit_mask = (paddr == `PWMIRQ_OFS_MASK);
  wire logic hit_set = (paddr == `PWMIRQ_OFS_MASK_SET);
  wire logic hit_clr = (paddr == `PWMIRQ_OFS_MASK_CLR);
  wire logic hit_stat = (paddr == `PWMIRQ_OFS_STATUS);
  wire logic hit_pend = (paddr == `PWMIRQ_OFS_PENDING);
  wire logic hit_on = (paddr == `PWMIRQ_OFS_MODULE);
  wire logic hit_wmode = (paddr == `PWMIRQ_OFS_WMODE);

  wire logic hit_any = hit_mask | hit_set | hit_clr | hit_stat | hit_pend | hit_on | hit_wmode;

  // zero wait states: every transfer completes in its first access cycle
  assign pready = 1'b1;
  // unmapped addresses answer with an error and have no effect
  assign pslverr = access_ph & ~hit_any;

  wire logic wr_mask = wr_en & hit_mask;
  wire logic wr_set = wr_en & hit_set;
  wire logic wr_clr = wr_en & hit_clr;
  wire logic wr_stat = wr_en & hit_stat;
  wire logic wr_on = wr_en & hit_on;
  wire logic wr_wmode = wr_en & hit_wmode;

  wire pwmirq_evt_t wr_bits = pwdata[7:0] & `PWMIRQ_EVT_VALID;

  // ----------------------------------------
  // interrupt enable bits
  // ----------------------------------------
  // all three views act on one vector, so they can never disagree
  wire pwmirq_evt_t mask_base = wr_mask ? wr_bits : mask_q;

  // only ones act; zero bits pass the old value through
  wire pwmirq_evt_t set_bits = wr_set ? wr_bits : `PWMIRQ_RST_EVT;
  wire pwmirq_evt_t clr_bits = wr_clr ? wr_bits : `PWMIRQ_RST_EVT;

  // halt-done enable set and clear
  // pattern-begin enables per sequence index
  // pattern-finish enables per sequence index
  // cycle-wrap enable
  // repeat-complete enable
  assign mask_d = (mask_base | set_bits) & ~clr_bits;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `PWMIRQ_RST_EVT;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------
  // module enable and wave mode
  // ----------------------------------------
  assign on_d = wr_on ? pwdata[`PWMIRQ_BIT_ON] : on_q;
  assign wmode_d = wr_wmode ? pwmirq_wave_e'(pwdata[`PWMIRQ_BIT_WMODE]) : wmode_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= `PWMIRQ_RST_BIT;
    end else begin
      on_q <= on_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wmode_q <= PWMIRQ_WAVE_UP;
    end else begin
      wmode_q <= wmode_d;
    end
  end

  assign module_on = on_q;
  assign wave_mode = wmode_q;

  // ----------------------------------------
  // event capture
  // ----------------------------------------
  // events are pulses from the modulator core; bit 0 has no event
  wire pwmirq_evt_t evt_in = {
    repeat_complete_event,
    cycle_wrap_event,
    pattern_finish_event[1],
    pattern_finish_event[0],
    pattern_begin_event[1],
    pattern_begin_event[0],
    halt_done_event,
    1'b0
  };

  assign evt.set = evt_in;
  assign evt.clr = wr_stat ? wr_bits : `PWMIRQ_RST_EVT;

  pwmirq_evt_flags u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .evt     (evt)
  );

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  wire pwmirq_evt_t pending = evt.flags & mask_q;
  wire logic irq_d = |pending;

  // registered so the line never glitches on decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= `PWMIRQ_RST_BIT;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // set and clear registers read back the live enables
  wire pwmirq_word_t rd_mux =
    (hit_mask | hit_set | hit_clr) ? {24'h00_0000, mask_q} :
    hit_stat                       ? {24'h00_0000, evt.flags} :
    hit_pend                       ? {24'h00_0000, pending} :
    hit_on                         ? {31'h0000_0000, on_q} :
    hit_wmode                      ? {31'h0000_0000, wmode_q} :
                                     `PWMIRQ_RST_WORD;

  // captured in the setup cycle so prdata is a flop during access
  assign rdata_d = (setup_ph & ~pwrite) ? rd_mux : rdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= `PWMIRQ_RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

endmodule

// File: tb/pwmirq_top_assertions.sv
`timescale 1ns/1ps
module pwmirq_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halt_done_event,
  input wire logic [1:0]  pattern_begin_event,
  input wire logic [1:0]  pattern_finish_event,
  input wire logic        cycle_wrap_event,
  input wire logic        repeat_complete_event,
  input wire logic        module_on,
  input wire logic        wave_mode,
  input wire logic        irq
);
  // ----
  // decode
  // ----
  logic acc, wr, rd, hit, msk, any, seen_q;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;
  assign msk = paddr inside {12'h300, 12'h304, 12'h308};
  assign hit = msk || (paddr inside {12'h320, 12'h324, 12'h500, 12'h504});
  assign any = halt_done_event || (|pattern_begin_event) || (|pattern_finish_event) || cycle_wrap_event
               || repeat_complete_event;
  // no flag can exist before the first event since reset, so irq must stay low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) seen_q <= 1'b0;
    else if (any) seen_q <= 1'b1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_on_wr; wr && paddr == 12'h500; endsequence
  sequence s_mode_wr; wr && paddr == 12'h504; endsequence
  chk_ready_acc: assert property (acc |-> pready) else $error("no ready");
  chk_err_unmap: assert property (acc && !hit |-> pslverr) else $error("no slverr");
  chk_err_quiet: assert property (!acc || hit |-> !pslverr) else $error("stray slverr");
  chk_rd_unmap: assert property (rd && !hit |-> prdata == 32'h0000_0000) else $error("unmapped data");
  chk_mask_bits:
    assert property (rd && msk |-> prdata[31:8] == 24'h00_0000 && !prdata[0]) else $error("mask stray bits");
  chk_on_write:
    assert property (s_on_wr |=> module_on == $past(pwdata[0])) else $error("enable not taken");
  chk_on_hold:
    assert property ($changed(module_on) |-> $past(wr && paddr == 12'h500)) else $error("enable moved");
  chk_mode_write:
    assert property (s_mode_wr |=> wave_mode == $past(pwdata[0])) else $error("mode not taken");
  chk_irq_cause: assert property (!seen_q |-> !irq) else $error("irq without event");
endmodule

// File: tb/pwm_irq_enable_ctrl_tb_top.sv
`timescale 1ns/1ps
module pwm_irq_enable_ctrl_tb_top
  import pwmirq_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, serr, pready, pslverr, module_on, wave_mode, irq;
  pwmirq_addr_t paddr;
  pwmirq_word_t pwdata, rd, exp;
  logic [31:0]  prdata;
  pwmirq_evt_t  evt;
  int           err_count, samples_checked;

  pwmirq_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .halt_done_event(evt[1]), .pattern_begin_event(evt[3:2]), .pattern_finish_event(evt[5:4]),
    .cycle_wrap_event(evt[6]), .repeat_complete_event(evt[7]), .module_on, .wave_mode, .irq);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----
  // helpers
  // ----
  task check(input pwmirq_word_t seen, input pwmirq_word_t want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task apb(input logic w, input pwmirq_addr_t a, input pwmirq_word_t d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin err_count++; give_verdict(); end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdchk(input pwmirq_addr_t a, input pwmirq_word_t want);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, want);
  endtask
  task settle(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    rdchk(12'h304, 32'h0000_0000);
    rdchk(12'h308, 32'h0000_0000);
    rdchk(12'h500, 32'h0000_0000);
    check(module_on, 32'h0000_0000);
  endtask
  task t_set;
    exp = 32'h0000_0000;
    for (int i = 1; i < 8; i++) begin
      apb(1'b1, 12'h304, 32'h0000_0001 << i);
      exp |= 32'h0000_0001 << i;
      rdchk(12'h304, exp);
      rdchk(12'h300, exp);
    end
    // zeros in bits 7:1 plus the reserved bit and ones in bits 31:8 must leave the enables alone
    apb(1'b1, 12'h304, 32'hFFFF_FF01);
    rdchk(12'h308, exp);
  endtask
  task t_clr;
    for (int i = 1; i < 8; i++) begin
      apb(1'b1, 12'h308, 32'h0000_0001 << i);
      exp &= ~(32'h0000_0001 << i);
      rdchk(12'h308, exp);
      rdchk(12'h304, exp);
    end
    apb(1'b1, 12'h300, 32'h0000_00AA);
    apb(1'b1, 12'h308, 32'h0000_0000);
    rdchk(12'h304, 32'h0000_00AA);
    apb(1'b1, 12'h300, 32'h0000_0000);
  endtask
  task t_on;
    apb(1'b1, 12'h500, 32'h0000_0001);
    settle(1);
    check(module_on, 32'h0000_0001);
    apb(1'b1, 12'h504, 32'h0000_0001);
    rdchk(12'h504, 32'h0000_0001);
    check(wave_mode, 32'h0000_0001);
    apb(1'b1, 12'h500, 32'h0000_0002);
    rdchk(12'h500, 32'h0000_0000);
    apb(1'b1, 12'h504, 32'h0000_0000);
  endtask
  task t_irq;
    @(posedge pclk) evt <= 8'h40;
    @(posedge pclk) evt <= 8'h00;
    settle(3);
    check(irq, 32'h0000_0000);
    rdchk(12'h320, 32'h0000_0040);
    apb(1'b1, 12'h304, 32'h0000_0040);
    settle(2);
    check(irq, 32'h0000_0001);
    rdchk(12'h324, 32'h0000_0040);
    apb(1'b1, 12'h308, 32'h0000_0040);
    settle(2);
    check(irq, 32'h0000_0000);
    apb(1'b1, 12'h304, 32'h0000_0040);
    apb(1'b1, 12'h320, 32'h0000_0040);
    settle(2);
    check(irq, 32'h0000_0000);
    rdchk(12'h320, 32'h0000_0000);
  endtask
  task t_bad;
    apb(1'b1, 12'h400, 32'hFFFF_FFFF);
    check(serr, 32'h0000_0001);
    apb(1'b0, 12'h400, 32'h0000_0000);
    check({serr, rd[30:0]}, 32'h8000_0000);
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; evt = 8'h00;
    err_count = 0; samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_set();
    t_clr();
    t_on();
    t_irq();
    t_bad();
    give_verdict();
  end
endmodule

bind pwmirq_top pwmirq_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .halt_done_event, .pattern_begin_event, .pattern_finish_event, .cycle_wrap_event,
  .repeat_complete_event, .module_on, .wave_mode, .irq);
